// >>> hw/pfp_top.v
`timescale 1ns/1ps
`include "pfp_defs.vh"
module pfp_top #(
    parameter [31:0] ILIM_CYC = `PFP_ILIM_MS * (`PFP_CLK_HZ / 32'h0000_03e8),
    parameter [31:0] MOVE_CYC = `PFP_MOVE_MS * (`PFP_CLK_HZ / 32'h0000_03e8),
    parameter [31:0] HOME_CYC = `PFP_HOME_MS * (`PFP_CLK_HZ / 32'h0000_03e8)
) (
    // clock and reset
    input wire clk,
    input wire rstn,
    // control value and range jumpers
    input wire [9:0] ctrl_val,
    input wire [1:0] span_sel,
    // feedback
    input wire pulse_in,
    input wire cur_at_limit,
    // motor drive
    output reg drive_en_ff,
    output reg drive_up_ff,
    output reg drive_slow_ff,
    // error, open collector
    output wire err_out,
    output wire err_oe_n,
    // status
    output reg [10:0] pos_ff,
    output reg [1:0] state_ff
);
    reg sync1_ff;
    reg sync2_ff;
    reg sync3_ff;
    reg [10:0] tgt_ff;
    reg [9:0] last_val_ff;
    reg trip_dir_ff;
    reg [1:0] nxt_state;
    reg [10:0] tgt;
    reg [10:0] diff;
    wire pulse_edge;
    wire home_quiet;
    wire ilim_trip;
    wire move_trip;
    wire val_new;
    wire want_up;
    wire move_start;
    wire [10:0] tgt_nxt;
    reg err_act_ff;

    // edge of the synchronised feedback pulse
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sync1_ff <= 1'b0;
            sync2_ff <= 1'b0;
            sync3_ff <= 1'b0;
        end else begin
            sync1_ff <= pulse_in;
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
        end
    end
    assign pulse_edge = sync2_ff & ~sync3_ff;

    // scale control value onto the chosen span
    always @* begin
        case (span_sel)
        `PFP_SPAN_128: tgt = {4'h0, ctrl_val[9:3]};
        `PFP_SPAN_256: tgt = {3'h0, ctrl_val[9:2]};
        `PFP_SPAN_512: tgt = {2'h0, ctrl_val[9:1]};
        `PFP_SPAN_1024: tgt = {1'b0, ctrl_val};
        default: tgt = {1'b0, ctrl_val};
        endcase
    end

    // direction asked for by the present command
    assign want_up = (tgt > pos_ff);
    assign val_new = (ctrl_val != last_val_ff);
    // target freezes while tripped, reloads on the clearing command
    assign tgt_nxt = (state_ff != `PFP_ST_TRIP || nxt_state == `PFP_ST_MOVE) ?
                     tgt : tgt_ff;
    // a move starts on entry into the move state
    assign move_start = (nxt_state == `PFP_ST_MOVE) &&
                        (state_ff != `PFP_ST_MOVE);

    // distance to go, for the slow-down window
    always @* begin
        if (tgt_nxt > pos_ff)
            diff = tgt_nxt - pos_ff;
        else
            diff = pos_ff - tgt_nxt;
    end

    // home: quiet time without pulses ends the search
    pfp_timer #(.LIMIT(HOME_CYC)) u_home (
        .clk(clk),
        .rstn(rstn),
        .run(state_ff == `PFP_ST_HOME),
        .restart(pulse_edge),
        .expired(home_quiet)
    );

    pfp_timer #(.LIMIT(ILIM_CYC)) u_ilim (
        .clk(clk),
        .rstn(rstn),
        .run(cur_at_limit && drive_en_ff),
        .restart(move_start),
        .expired(ilim_trip)
    );

    pfp_timer #(.LIMIT(MOVE_CYC)) u_move (
        .clk(clk),
        .rstn(rstn),
        .run(state_ff == `PFP_ST_MOVE),
        .restart(val_new || move_start),
        .expired(move_trip)
    );

    // operating sequence: home, idle, move, trip
    always @* begin
        nxt_state = state_ff;
        case (state_ff)
        `PFP_ST_HOME: begin
            if (ilim_trip)
                nxt_state = `PFP_ST_TRIP;
            else if (home_quiet)
                nxt_state = `PFP_ST_IDLE;
        end
        `PFP_ST_IDLE: begin
            if (tgt_ff != pos_ff)
                nxt_state = `PFP_ST_MOVE;
        end
        `PFP_ST_MOVE: begin
            if (ilim_trip || move_trip)
                nxt_state = `PFP_ST_TRIP;
            else if (tgt_ff == pos_ff)
                nxt_state = `PFP_ST_IDLE;
        end
        `PFP_ST_TRIP: begin
            if (tgt != pos_ff && want_up != trip_dir_ff)
                nxt_state = `PFP_ST_MOVE;
        end
        default: nxt_state = `PFP_ST_HOME;
        endcase
    end

    // state register
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_ff <= `PFP_ST_HOME;
            last_val_ff <= 10'h000;
        end else begin
            state_ff <= nxt_state;
            last_val_ff <= ctrl_val;
        end
    end

    // target register
    always @(posedge clk or negedge rstn) begin
        if (!rstn)
            tgt_ff <= 11'h000;
        else
            tgt_ff <= tgt_nxt;
    end

    // direction of the drive that tripped, for the reverse clear
    always @(posedge clk or negedge rstn) begin
        if (!rstn)
            trip_dir_ff <= 1'b0;
        else if (nxt_state == `PFP_ST_TRIP && state_ff != `PFP_ST_TRIP)
            trip_dir_ff <= drive_up_ff;
    end

    // error indication follows the trip state
    always @(posedge clk or negedge rstn) begin
        if (!rstn)
            err_act_ff <= 1'b0;
        else
            err_act_ff <= (nxt_state == `PFP_ST_TRIP);
    end

    // position tracking
    always @(posedge clk or negedge rstn) begin
        if (!rstn)
            pos_ff <= 11'h000;
        else if (state_ff == `PFP_ST_HOME && home_quiet)
            pos_ff <= 11'h000;
        else if (pulse_edge && state_ff != `PFP_ST_HOME) begin
            if (drive_up_ff)
                pos_ff <= pos_ff + 11'h001;
            else if (pos_ff != 11'h000)
                pos_ff <= pos_ff - 11'h001;
        end
    end

    // motor drive outputs
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            drive_en_ff <= 1'b0;
            drive_up_ff <= 1'b0;
            drive_slow_ff <= 1'b0;
        end else begin
            case (nxt_state)
            `PFP_ST_HOME: begin
                drive_en_ff <= 1'b1;
                drive_up_ff <= 1'b0;
                drive_slow_ff <= 1'b0;
            end
            `PFP_ST_MOVE: begin
                drive_en_ff <= 1'b1;
                drive_up_ff <= (tgt_nxt > pos_ff);
                drive_slow_ff <= (diff <= `PFP_SLOW_CNT);
            end
            default: begin
                drive_en_ff <= 1'b0;
                drive_slow_ff <= 1'b0;
            end
            endcase
        end
    end

    assign err_out = 1'b0;
    // open collector: enable low pulls the error line
    assign err_oe_n = ~err_act_ff;
endmodule

// >>> hw/pfp_defs.vh
// Function
// - four spans: 128, 256, 512, 1024 pulses
// - two jumpers select the span
// - up-down counter follows feedback pulses
// - power-up homes, clears, then positions
// - home when pulses stop; count zero
// - new control value starts motor, compares
// - slow near target, stop when equal
// - current limit over 2s trips
// - move over 50s without a new control value trips
// - error output held during fault
// - reverse command or power cycle clears trip
`ifndef PFP_DEFS_VH
`define PFP_DEFS_VH
`define PFP_CLK_HZ 32'h0098_9680
`define PFP_ILIM_MS 32'h0000_07d0
`define PFP_MOVE_MS 32'h0000_c350
`define PFP_HOME_MS 32'h0000_0064
`define PFP_SLOW_CNT 11'h010
`define PFP_SPAN_128 2'h0
`define PFP_SPAN_256 2'h1
`define PFP_SPAN_512 2'h2
`define PFP_SPAN_1024 2'h3
`define PFP_ST_HOME 2'h0
`define PFP_ST_IDLE 2'h1
`define PFP_ST_MOVE 2'h2
`define PFP_ST_TRIP 2'h3
`endif

// >>> hw/pfp_timer.v
`timescale 1ns/1ps
`include "pfp_defs.vh"
module pfp_timer #(
    parameter [31:0] LIMIT = 32'h0000_0010
) (
    // clock and reset
    input wire clk,
    input wire rstn,
    // control
    input wire run,
    input wire restart,
    // result
    output wire expired
);
    reg [31:0] cnt_ff;
    wire [31:0] nxt_cnt;
    // counts only an unbroken run of the condition
    assign nxt_cnt = (!run || restart) ? 32'h0000_0000 :
                     (cnt_ff >= LIMIT) ? cnt_ff : cnt_ff + 32'h0000_0001;
    assign expired = (cnt_ff >= LIMIT);
    always @(posedge clk or negedge rstn) begin
        if (!rstn)
            cnt_ff <= 32'h0000_0000;
        else
            cnt_ff <= nxt_cnt;
    end
endmodule

// >>> verif/pfp_monitor.sv
`timescale 1ns/1ps
module pfp_monitor #(
    parameter [31:0] ILIM_CYC = 32'h32
) (
    // clock and reset
    input wire clk,
    input wire rstn,
    // inputs
    input wire [9:0] ctrl_val,
    input wire [1:0] span_sel,
    input wire cur_at_limit,
    // outputs
    input wire drive_en_ff,
    input wire drive_up_ff,
    input wire drive_slow_ff,
    input wire err_oe_n,
    input wire [10:0] pos_ff,
    input wire [1:0] state_ff
);
    reg [31:0] lim_ff;
    wire [10:0] tgt = {1'b0, ctrl_val} >> (2'h3 - span_sel);
    wire [10:0] dif = tgt > pos_ff ? tgt - pos_ff : pos_ff - tgt;
    wire run_lim = cur_at_limit && drive_en_ff;
    // unbroken cycles at the current limit while driving
    always @(posedge clk or negedge rstn) begin
        if (!rstn)
            lim_ff <= 32'h0;
        else if (run_lim)
            lim_ff <= lim_ff + 32'h1;
        else
            lim_ff <= 32'h0;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    trip_err_a: assert property (err_oe_n == (state_ff != 2'h3))
        else $error("error line wrong");
    trip_off_a: assert property (state_ff == 2'h3 |-> !drive_en_ff)
        else $error("drive on in trip");
    home_dir_a: assert property (state_ff == 2'h0 && drive_en_ff
        |-> !drive_up_ff) else $error("homing wrong way");
    home_zero_a: assert property ((state_ff == 2'h0 ##1 state_ff == 2'h1)
        |-> pos_ff == 11'h0) else $error("home count not zero");
    pos_step_a: assert property (pos_ff != $past(pos_ff) |->
        pos_ff == 11'h0 || pos_ff == $past(pos_ff) + 11'h1 ||
        pos_ff == $past(pos_ff) - 11'h1) else $error("count jumped");
    cnt_once_a: assert property ($changed(pos_ff) && pos_ff != 11'h0
        |=> $stable(pos_ff)) else $error("pulse counted twice");
    up_dir_a: assert property (pos_ff == $past(pos_ff) + 11'h1 |->
        $past(drive_up_ff)) else $error("count up while down");
    tgt_stop_a: assert property (state_ff == 2'h2 && pos_ff == tgt
        |-> ##[1:2] !drive_en_ff) else $error("no stop at target");
    near_slow_a: assert property ((state_ff == 2'h2 && dif <= 11'h10)
        [*3] |-> drive_slow_ff) else $error("no slow near target");
    far_fast_a: assert property ((state_ff == 2'h2 && dif > 11'h10)
        [*3] |-> !drive_slow_ff) else $error("slow far from target");
    ilim_trip_a: assert property (lim_ff == ILIM_CYC + 32'h1 |->
        state_ff == 2'h3) else $error("no current trip");
    cover property (state_ff == 2'h3);
    cover property (state_ff == 2'h2 ##1 state_ff == 2'h1);
    cover property (drive_slow_ff && drive_en_ff);
    cover property (state_ff == 2'h3 ##1 state_ff == 2'h2);
endmodule
bind pfp_top pfp_monitor #(.ILIM_CYC(ILIM_CYC)) u_mon (.clk(clk), .rstn(rstn),
    .ctrl_val(ctrl_val), .span_sel(span_sel), .cur_at_limit(cur_at_limit),
    .drive_en_ff(drive_en_ff), .drive_up_ff(drive_up_ff),
    .drive_slow_ff(drive_slow_ff), .err_oe_n(err_oe_n), .pos_ff(pos_ff),
    .state_ff(state_ff));

// >>> verif/pfp_motor.sv
`timescale 1ns/1ps
module pfp_motor (
    // drive
    input wire clk,
    input wire drive_en_ff,
    input wire drive_up_ff,
    // feedback
    output reg pulse_in
);
    integer mech = 5;
    integer ph = 0;
    initial pulse_in = 1'b0;
    // limit switch at home end swallows the pulses
    always @(posedge clk) begin
        ph <= drive_en_ff && (drive_up_ff || mech > 0) ?
              (ph + 1) % 8 : 0;
        if (ph == 7)
            mech <= drive_up_ff ? mech + 1 : mech - 1;
        pulse_in <= #1 ph >= 4;
    end
endmodule

// >>> verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    reg clk = 1'b0;
    reg rstn = 1'b0;
    reg [9:0] ctrl_val = 10'h0;
    reg [1:0] span_sel = 2'h0;
    reg cur_at_limit = 1'b0;
    wire pulse_in, drive_en_ff, drive_up_ff, drive_slow_ff, err_out, err_oe_n;
    wire [10:0] pos_ff;
    wire [1:0] state_ff;
    integer n_fail = 0;
    integer n_tests = 0;
    integer i;
    reg [22:0] rows [0:3];
    always #50 clk = ~clk;
    pfp_top #(.ILIM_CYC(32'h32), .MOVE_CYC(32'h190), .HOME_CYC(32'h14)) u_dut (
        .clk(clk), .rstn(rstn), .ctrl_val(ctrl_val), .span_sel(span_sel),
        .pulse_in(pulse_in), .cur_at_limit(cur_at_limit),
        .drive_en_ff(drive_en_ff), .drive_up_ff(drive_up_ff),
        .drive_slow_ff(drive_slow_ff), .err_out(err_out),
        .err_oe_n(err_oe_n), .pos_ff(pos_ff), .state_ff(state_ff));
    pfp_motor u_mot (.clk(clk), .drive_en_ff(drive_en_ff),
        .drive_up_ff(drive_up_ff), .pulse_in(pulse_in));
    task test_done;
        begin
            $display("fails %0d of %0d", n_fail, n_tests);
            if (n_fail == 0 && n_tests > 0)
                $display("TEST PASSED");
            else
                $display("TEST FAILED");
            $finish;
        end
    endtask
    task chk(input string nm, input [10:0] e, input [10:0] g);
        begin
            n_tests = n_tests + 1;
            if (g !== e) begin
                n_fail = n_fail + 1;
                $display("Error %0s exp %h got %h", nm, e, g);
            end
        end
    endtask
    task cy(input integer n);
        begin
            repeat (n) @(posedge clk);
            #1;
        end
    endtask
    task wt(input [1:0] s);
        integer k;
        begin
            for (k = 0; k < 3000 && state_ff !== s; k = k + 1)
                cy(1);
            chk("state", {9'h0, s}, {9'h0, state_ff});
            if (state_ff !== s)
                test_done;
        end
    endtask
    initial begin
        rows[0] = {2'h0, 10'h0a0, 11'h014};
        rows[1] = {2'h1, 10'h038, 11'h00e};
        rows[2] = {2'h2, 10'h030, 11'h018};
        rows[3] = {2'h3, 10'h00a, 11'h00a};
        cy(4);
        chk("oe_n", 11'h1, err_oe_n);
        chk("state", 11'h0, state_ff);
        rstn = 1'b1;
        cy(2);
        chk("up", 11'h0, drive_up_ff);
        chk("en", 11'h1, drive_en_ff);
        wt(2'h1);
        chk("pos", 11'h0, pos_ff);
        for (i = 0; i < 4; i = i + 1) begin
            {span_sel, ctrl_val} = rows[i][22:11];
            wt(2'h2);
            wt(2'h1);
            chk("pos", rows[i][10:0], pos_ff);
            chk("en", 11'h0, drive_en_ff);
        end
        ctrl_val = 10'h030;
        cy(5);
        cur_at_limit = 1'b1;
        cy(40);
        cur_at_limit = 1'b0;
        cy(1);
        cur_at_limit = 1'b1;
        cy(40);
        chk("state", 11'h2, state_ff);
        chk("slow", 11'h0, drive_slow_ff);
        wt(2'h3);
        cur_at_limit = 1'b0;
        ctrl_val = 10'h040;
        cy(5);
        chk("state", 11'h3, state_ff);
        chk("oe_n", 11'h0, err_oe_n);
        chk("err", 11'h0, err_out);
        ctrl_val = 10'h005;
        wt(2'h1);
        chk("pos", 11'h005, pos_ff);
        ctrl_val = 10'h3ff;
        wt(2'h3);
        chk("en", 11'h0, drive_en_ff);
        rstn = 1'b0;
        cy(2);
        chk("state", 11'h0, state_ff);
        rstn = 1'b1;
        wt(2'h1);
        chk("oe_n", 11'h1, err_oe_n);
        chk("pos", 11'h0, pos_ff);
        test_done;
    end
endmodule
